// [rtl/failsafe_regs.svh]
`ifndef FAILSAFE_REGS_SVH
`define FAILSAFE_REGS_SVH

// Timebase and durations, each in its own unit.
`define CLK_PERIOD_NS         8
`define TXD_DOM_TIMEOUT_US    2000
`define RXD_CLAMP_TIME_US     2
`define BUS_DOM_TIMEOUT_US    2000
`define SHORT_FILTER_US       1
`define WAKE_FILTER_US        1
`define WAKE_TIMEOUT_US       1000
`define US_TO_CYC(us) (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Register byte offsets on the Avalon slave.
`define REG_CTRL_OFS          4'h0
`define REG_STATUS_OFS        4'h4
`define REG_WAKE_OFS          4'h8

// Field positions.
`define CTRL_MODE_LSB         0
`define WAKE_CLR_BIT          0
`define RDATA_IDLE            32'h0000_0000

`endif

// [rtl/failsafe_pkg.sv]
package failsafe_pkg;

  // Operating modes written by software.
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_SILENT  = 2'h1,
    MODE_NORMAL  = 2'h2
  } mode_t;

  // Wake pattern recogniser, Gray coded along the pattern.
  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_DOM1 = 2'h1,
    W_REC  = 2'h3,
    W_DOM2 = 2'h2
  } wake_state_t;

  // Causes of a local failure.
  typedef struct packed {
    logic txd_dom;
    logic pin_short;
    logic rx_clamp;
    logic bus_clamp;
    logic overtemp;
  } fail_t;

  // Status word layout, most significant field first.
  typedef struct packed {
    wake_state_t wake_state;
    logic        wake_seen;
    logic        tx_enable;
    logic        any_uv;
    logic        local_failure_flag;
    fail_t       fail;
  } status_t;

endpackage

// [rtl/dur_timer.sv]
`timescale 1ns/1ps
`default_nettype none

// Counts how long a level has held; expires one edge after TERM is reached.
module dur_timer #(
  parameter int unsigned CNT_W = 24,
  parameter int unsigned TERM  = 8
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_run,
  output logic      o_expired
);

  localparam logic [CNT_W-1:0] TERM_C = CNT_W'(TERM);

  logic [CNT_W-1:0] cnt;

  // Counter saturates so a level held forever never wraps into a false restart.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
    end else if (!i_run) begin
      cnt <= '0;
    end else if (cnt != TERM_C) begin
      cnt <= cnt + 1'b1;
    end
  end

  // Expiry means the level lasted longer than the terminal count.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= i_run && (cnt == TERM_C);
    end
  end

endmodule

`default_nettype wire

// [rtl/can_failsafe_monitor.sv]
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "failsafe_regs.svh"

module can_failsafe_monitor #(
  parameter int unsigned CNT_W       = 24,
  parameter int unsigned TXD_DOM_CYC = `US_TO_CYC(`TXD_DOM_TIMEOUT_US),
  parameter int unsigned RXC_CYC     = `US_TO_CYC(`RXD_CLAMP_TIME_US),
  parameter int unsigned BUS_DOM_CYC = `US_TO_CYC(`BUS_DOM_TIMEOUT_US),
  parameter int unsigned SHORT_CYC   = `US_TO_CYC(`SHORT_FILTER_US),
  parameter int unsigned FILT_CYC    = `US_TO_CYC(`WAKE_FILTER_US),
  parameter int unsigned WAKE_TO_CYC = `US_TO_CYC(`WAKE_TIMEOUT_US)
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rstn,
  input  wire logic [3:0]      i_avs_address,
  input  wire logic            i_avs_read,
  input  wire logic            i_avs_write,
  input  wire logic [31:0]     i_avs_writedata,
  input  wire logic [3:0]      i_avs_byteenable,
  output logic [31:0]          o_avs_readdata,
  output logic                 o_avs_waitrequest,
  input  wire logic            i_txd,
  input  wire logic            i_rxd_sense,
  input  wire logic            i_bus_state_comparator_out,
  input  wire logic            i_overtemp,
  input  wire logic            i_main_supply_uv_level,
  input  wire logic            i_driver_supply_uv_level,
  input  wire logic            i_io_supply_uv_level,
  output logic                 o_rxd,
  output logic                 o_tx_enable,
  output logic                 o_tx_dominant,
  output logic                 o_error_flag_out_n,
  output logic                 o_engaged,
  output logic                 o_wake_comparator_on,
  output logic                 o_local_wake_enable,
  output logic                 o_bus_wake,
  output failsafe_pkg::fail_t  o_fail_cause
);

  import failsafe_pkg::*;

  localparam logic [CNT_W-1:0] FILT_C    = CNT_W'(FILT_CYC);
  localparam logic [CNT_W-1:0] WAKE_TO_C = CNT_W'(WAKE_TO_CYC);

  mode_t            mode;
  fail_t            fail;
  logic             local_failure_flag;
  logic             wake_seen;
  wake_state_t      wstate;
  wake_state_t      next_wstate;
  logic [CNT_W-1:0] phase_cnt;
  logic [CNT_W-1:0] win_cnt;
  logic             bus_dom;
  logic             any_uv;
  logic             mon;
  logic             txd_exp;
  logic             rxc_exp;
  logic             bus_exp;
  logic             short_exp;
  logic             wr_en;
  logic             rd_en;
  logic             wr_ctrl;
  mode_t            wr_mode;
  logic             enter_normal;
  logic             resolved;
  logic             lf_clear;
  logic             lf_set;
  logic             rxc_set;
  logic             held_cause;
  logic             next_tx_enable;
  logic             wake_en;
  logic             phase_ok;
  logic             win_out;
  logic             wake_hit;
  status_t          status;

  //////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the access completes.

  // Bus levels and qualifiers used everywhere below.
  assign bus_dom = i_bus_state_comparator_out;
  assign any_uv  = i_main_supply_uv_level | i_driver_supply_uv_level
                 | i_io_supply_uv_level;
  assign mon     = ((mode == MODE_NORMAL) || (mode == MODE_SILENT))
                 && !any_uv;
  assign wr_en   = i_avs_write && !o_avs_waitrequest;
  assign rd_en   = i_avs_read && o_avs_waitrequest;
  assign wr_ctrl = wr_en && (i_avs_address == `REG_CTRL_OFS)
                 && i_avs_byteenable[0];
  assign wr_mode = mode_t'(i_avs_writedata[`CTRL_MODE_LSB +: 2]);
  assign enter_normal = wr_ctrl && (wr_mode == MODE_NORMAL)
                      && (mode != MODE_NORMAL);

  // Waitrequest drops for exactly one cycle per request, so the master
  // always completes on the second edge of its request.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Status word shows the block's own state.
  assign status = '{wake_state: wstate, wake_seen: wake_seen,
                    tx_enable: o_tx_enable, any_uv: any_uv,
                    local_failure_flag: local_failure_flag, fail: fail};

  // Read data is captured in the wait cycle; unmapped offsets read zero.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= `RDATA_IDLE;
    end else if (rd_en) begin
      case (i_avs_address)
        `REG_CTRL_OFS:   o_avs_readdata <= 32'(mode);
        `REG_STATUS_OFS: o_avs_readdata <= 32'(status);
        `REG_WAKE_OFS:   o_avs_readdata <= 32'(wake_seen);
        default:         o_avs_readdata <= `RDATA_IDLE;
      endcase
    end
  end

  // Mode register; the unused encoding is ignored rather than stored.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode <= MODE_STANDBY;
    end else if (wr_ctrl && (i_avs_writedata[`CTRL_MODE_LSB +: 2] != 2'h3))
    begin
      mode <= wr_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Duration timers.

  // Runs while transmit is held low by the controller.
  dur_timer #(.CNT_W(CNT_W), .TERM(TXD_DOM_CYC)) u_txd_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_run     (mon && !i_txd),
    .o_expired (txd_exp)
  );

  // Runs while the comparator says dominant but the pin stays high.
  dur_timer #(.CNT_W(CNT_W), .TERM(RXC_CYC)) u_rxc_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_run     (mon && bus_dom && i_rxd_sense),
    .o_expired (rxc_exp)
  );

  // Runs while the bus stays dominant.
  dur_timer #(.CNT_W(CNT_W), .TERM(BUS_DOM_CYC)) u_bus_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_run     (mon && bus_dom),
    .o_expired (bus_exp)
  );

  // Runs while the pin level disagrees with what this block drives; a
  // short latches pin_short, which turns the transmitter off.
  dur_timer #(.CNT_W(CNT_W), .TERM(SHORT_CYC)) u_short_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_run     (mon && (i_rxd_sense != o_rxd)),
    .o_expired (short_exp)
  );

  //////////////////////////////////////////////////////////////////////////
  // Failure latches and the shared flag.

  // A failure counts as resolved only once every live condition is gone.
  assign resolved = !txd_exp && !short_exp && !rxc_exp && !bus_exp
                  && !i_overtemp;
  assign lf_clear = (enter_normal || (!o_rxd && i_txd)) && resolved;
  assign rxc_set  = mon && rxc_exp && i_rxd_sense && bus_dom;
  assign lf_set   = mon && (txd_exp || short_exp || i_overtemp || rxc_set
                  || bus_exp);
  assign held_cause = fail.txd_dom || fail.pin_short || fail.rx_clamp
                    || fail.overtemp;

  // Transmit-disabling causes hold until the flag clears; set beats clear.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fail.txd_dom   <= 1'b0;
      fail.pin_short <= 1'b0;
      fail.overtemp  <= 1'b0;
    end else begin
      fail.txd_dom   <= (mon && txd_exp) || (fail.txd_dom && !lf_clear);
      fail.pin_short <= (mon && short_exp)
                     || (fail.pin_short && !lf_clear);
      fail.overtemp  <= (mon && i_overtemp)
                     || (fail.overtemp && !lf_clear);
    end
  end

  // Receive clamp has its own release conditions, including power loss.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fail.rx_clamp <= 1'b0;
    end else if (rxc_set) begin
      fail.rx_clamp <= 1'b1;
    end else if (enter_normal || !i_rxd_sense || any_uv) begin
      fail.rx_clamp <= 1'b0;
    end
  end

  // Bus clamping is a live reflection of the timer and never held.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fail.bus_clamp <= 1'b0;
    end else begin
      fail.bus_clamp <= bus_exp && bus_dom;
    end
  end

  // Set wins over clear; a bus clamp alone is released with the bus.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      local_failure_flag <= 1'b0;
    end else if (lf_set) begin
      local_failure_flag <= 1'b1;
    end else if (lf_clear) begin
      local_failure_flag <= 1'b0;
    end else if (!bus_dom && !held_cause) begin
      local_failure_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin outputs.

  // Bus clamping deliberately leaves the transmitter alone.
  assign next_tx_enable = (mode == MODE_NORMAL) && !any_uv && !fail.txd_dom
                        && !fail.pin_short && !fail.overtemp
                        && !fail.rx_clamp;

  // All pin outputs are registered.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_enable          <= 1'b0;
      o_tx_dominant        <= 1'b0;
      o_rxd                <= 1'b1;
      o_error_flag_out_n   <= 1'b1;
      o_engaged            <= 1'b0;
      o_wake_comparator_on <= 1'b0;
      o_local_wake_enable  <= 1'b0;
      o_fail_cause         <= '0;
    end else begin
      o_tx_enable          <= next_tx_enable;
      o_tx_dominant        <= next_tx_enable && !i_txd;
      o_rxd                <= any_uv || !bus_dom;
      o_error_flag_out_n   <= !local_failure_flag;
      o_engaged            <= !any_uv;
      o_wake_comparator_on <= !i_main_supply_uv_level;
      o_local_wake_enable  <= !i_main_supply_uv_level;
      o_fail_cause         <= fail;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus wake-up pattern filter.

  assign wake_en  = (mode == MODE_STANDBY) && !i_main_supply_uv_level;
  assign phase_ok = (phase_cnt >= FILT_C);
  assign win_out  = (win_cnt >= WAKE_TO_C);
  assign wake_hit = wake_en && (wstate == W_DOM2) && phase_ok && !win_out;

  // A long dominant sits in the first phase until the window expires and
  // restarts, so only the part after its last restart counts as the first dominant phase.
  always_comb begin
    next_wstate = wstate;
    if (!wake_en || ((wstate != W_IDLE) && win_out)) begin
      next_wstate = W_IDLE;
    end else begin
      case (wstate)
        W_IDLE: begin
          if (bus_dom) next_wstate = W_DOM1;
        end
        W_DOM1: begin
          if (!bus_dom) next_wstate = phase_ok ? W_REC : W_IDLE;
        end
        W_REC: begin
          if (bus_dom) next_wstate = phase_ok ? W_DOM2 : W_DOM1;
        end
        W_DOM2: begin
          if (phase_ok || !bus_dom) next_wstate = W_IDLE;
        end
        default: begin
          next_wstate = W_IDLE;
        end
      endcase
    end
  end

  // State, phase length and pattern window counters.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wstate    <= W_IDLE;
      phase_cnt <= '0;
      win_cnt   <= '0;
    end else begin
      wstate    <= next_wstate;
      phase_cnt <= (next_wstate != wstate) ? '0
                 : (phase_ok ? phase_cnt : phase_cnt + 1'b1);
      win_cnt   <= (next_wstate == W_IDLE) ? '0
                 : (win_out ? win_cnt : win_cnt + 1'b1);
    end
  end

  // Wake pulse and sticky bit; writing one clears, a new hit wins.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bus_wake <= 1'b0;
      wake_seen  <= 1'b0;
    end else begin
      o_bus_wake <= wake_hit;
      wake_seen  <= wake_hit || (wake_seen && !(wr_en
                 && (i_avs_address == `REG_WAKE_OFS) && i_avs_byteenable[0]
                 && i_avs_writedata[`WAKE_CLR_BIT]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_txd_expire;
    mon && txd_exp;
  endsequence

  sequence s_rxc_hit;
    rxc_set && !lf_clear;
  endsequence

  txd_timer_start_a: assert property (mon && i_txd |=> !txd_exp)
    else $error("transmit timer did not restart on high transmit");
  txd_tx_off_a: assert property (s_txd_expire |=> fail.txd_dom ##1 !o_tx_enable)
    else $error("transmit time-out did not disable transmitter");
  tx_held_off_a: assert property (fail.txd_dom && !lf_clear |=> fail.txd_dom)
    else $error("transmit disable released before flag cleared");
  rx_clamp_set_a: assert property (s_rxc_hit |=> fail.rx_clamp && local_failure_flag)
    else $error("receive clamp not flagged");
  rx_clamp_clr_a: assert property (fail.rx_clamp && !i_rxd_sense |=> !fail.rx_clamp)
    else $error("receive clamp not released by low pin");
  bus_clamp_drop_a: assert property (!bus_dom |=> !fail.bus_clamp)
    else $error("bus clamp held after recessive bus");
  rxd_follow_a: assert property (!any_uv && bus_dom |=> !o_rxd)
    else $error("receive output not low on dominant bus");
  uv_off_a: assert property (any_uv |=> !o_tx_enable && !o_engaged)
    else $error("transceiver not disengaged in undervoltage");
  wake_cmp_off_a: assert property (i_main_supply_uv_level |=> !o_wake_comparator_on && !o_local_wake_enable)
    else $error("wake detection not off in main undervoltage");
  error_flag_out_n_level_a: assert property (local_failure_flag |=> !o_error_flag_out_n)
    else $error("error output not low for set flag");
  wake_cause_a: assert property (o_bus_wake |-> $past(wstate) == W_DOM2 && $past(phase_ok))
    else $error("wake without second dominant phase");
  wake_window_a: assert property (wake_en && wstate != W_IDLE && win_out |=> wstate == W_IDLE)
    else $error("wake window not enforced");
  flag_release_a: assert property (!bus_dom && !lf_set && !held_cause
    |=> !local_failure_flag) else $error("bus clamp flag held");

endmodule

`default_nettype wire

// [tb/can_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Protocol controller seen from the transceiver's logic pins.
module can_ctrl_model (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_bit,
  input  wire logic i_hold_low,
  input  wire logic i_clamp_high,
  input  wire logic i_rxd,
  output logic      o_txd,
  output logic      o_rxd_pin
);
  logic [1:0] phase;
  logic [2:0] dom_run;
  logic       bit_q;
  logic       next_bit;

  ////////////////////////////////////////////////////////////////////////////
  // A recessive bit is forced after five dominant ones, so a legitimate
  // dominant phase never outlasts the transmit time-out.
  assign next_bit = i_bit | (dom_run == 3'h5);

  // Each bit lasts four clocks.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase   <= 2'h0;
      dom_run <= 3'h0;
      bit_q   <= 1'b1;
    end else begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        bit_q   <= next_bit;
        dom_run <= next_bit ? 3'h0 : dom_run + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A stuck transmit line and a receive pin clamped high are faults that
  // the bench commands; otherwise the pin shows what the device drives.
  assign o_txd     = bit_q & ~i_hold_low;
  assign o_rxd_pin = i_clamp_high | i_rxd;
endmodule

`default_nettype wire

// [tb/can_transceiver_failsafe_monitor_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module can_transceiver_failsafe_monitor_tb;
  import failsafe_pkg::*;

  localparam int TXD = 40;
  logic        i_sys_clk = 1'b0;
  logic        i_rstn    = 1'b0;
  logic [3:0]  adr       = 4'h0;
  logic        rd_q      = 1'b0;
  logic        wr_q      = 1'b0;
  logic [31:0] wdat      = 32'h0;
  logic [3:0]  be        = 4'hF;
  logic [31:0] rdat;
  logic        wait_q;
  logic        txd, rxd_pin, bus_dom;
  logic        ext_dom   = 1'b0;
  logic        overtemp  = 1'b0;
  logic [2:0]  uv        = 3'h0;
  logic        ctl_bit   = 1'b1;
  logic        hold_low  = 1'b0;
  logic        clamp     = 1'b0;
  logic        rxd, tx_en, tx_dom, err_n, engaged, wake_cmp, lwake, wake;
  fail_t       cause;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          wakes = 0;
  int          err_cyc = 0;
  int          seed = 32'hE61C;
  int          pat [5][4] = '{'{12, 12, 12, 1}, '{4, 12, 12, 0},
                              '{12, 4, 12, 0}, '{12, 100, 12, 0},
                              '{200, 12, 4, 0}};

  // The bus is dominant when this node or any other node drives it.
  assign bus_dom = tx_dom | ext_dom;
  always #4 i_sys_clk = ~i_sys_clk;

  can_failsafe_monitor #(.TXD_DOM_CYC(TXD), .RXC_CYC(20), .BUS_DOM_CYC(60),
    .SHORT_CYC(10), .FILT_CYC(8), .WAKE_TO_CYC(100)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(adr),
    .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_q), .i_txd(txd), .i_rxd_sense(rxd_pin),
    .i_bus_state_comparator_out(bus_dom), .i_overtemp(overtemp),
    .i_main_supply_uv_level(uv[0]), .i_driver_supply_uv_level(uv[1]),
    .i_io_supply_uv_level(uv[2]), .o_rxd(rxd), .o_tx_enable(tx_en),
    .o_tx_dominant(tx_dom), .o_error_flag_out_n(err_n),
    .o_engaged(engaged), .o_wake_comparator_on(wake_cmp),
    .o_local_wake_enable(lwake), .o_bus_wake(wake), .o_fail_cause(cause));

  can_ctrl_model i_ctrl (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_bit(ctl_bit), .i_hold_low(hold_low), .i_clamp_high(clamp),
    .i_rxd(rxd), .o_txd(txd), .o_rxd_pin(rxd_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // One Avalon word; the request stands until waitrequest is seen low.
  task automatic bus_op(input logic w, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] r);
    @(posedge i_sys_clk);
    adr  <= a;
    wdat <= d;
    wr_q <= w;
    rd_q <= ~w;
    do begin
      @(posedge i_sys_clk);
    end while (wait_q !== 1'b0);
    r = rdat;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask

  // Leaving and re-entering Normal clears resolved failures.
  task automatic renormal();
    logic [31:0] r;
    bus_op(1'b1, 4'h0, 32'h1, r);
    bus_op(1'b1, 4'h0, 32'h2, r);
    tick(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Cycle count, wake pulses and error time; a hang ends the run.
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (err_n !== 1'b1) err_cyc <= err_cyc + 1;
    if (cycles == 12000) begin
      fail_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    tick(20);
    i_rstn <= 1'b1;
    tick(3);
    check_bit("error_n after reset", 1'b1, err_n);
    check_bit("engaged", 1'b1, engaged);
    bus_op(1'b0, 4'h0, 32'h0, r);
    check_word("ctrl reset", 32'h0, r);
    bus_op(1'b0, 4'hC, 32'h0, r);
    check_word("unmapped read", 32'h0, r);
    bus_op(1'b1, 4'h0, 32'h3, r);
    bus_op(1'b0, 4'h0, 32'h0, r);
    check_word("ctrl mode 3", 32'h0, r);
    renormal();
    bus_op(1'b0, 4'h0, 32'h0, r);
    check_word("ctrl normal", 32'h2, r);
    // Random frames never trip the transmit timer.
    err_cyc = 0;
    repeat (100) begin
      ctl_bit <= 1'($random(seed));
      tick(4);
    end
    ctl_bit <= 1'b1;
    tick(8);
    check_word("error time", 32'h0, 32'(err_cyc));
    check_word("cause random", 32'h0, 32'(cause));
    // A low phase just short of the time-out restarts the timer.
    hold_low <= 1'b1;
    tick(TXD - 5);
    hold_low <= 1'b0;
    tick(3);
    hold_low <= 1'b1;
    tick(TXD - 5);
    hold_low <= 1'b0;
    tick(5);
    check_bit("no txd timeout", 1'b0, cause.txd_dom);
    hold_low <= 1'b1;
    tick(TXD + 6);
    check_bit("txd timeout", 1'b1, cause.txd_dom);
    check_bit("tx off", 1'b0, tx_en);
    check_bit("error_n low", 1'b0, err_n);
    hold_low <= 1'b0;
    tick(10);
    check_bit("tx stays off", 1'b0, tx_en);
    bus_op(1'b0, 4'h4, 32'h0, r);
    check_word("status txd", 32'h30, r);
    renormal();
    check_bit("flag cleared", 1'b1, err_n);
    check_bit("tx back on", 1'b1, tx_en);
    // Receive pin clamped high while another node drives dominant.
    clamp   <= 1'b1;
    ext_dom <= 1'b1;
    tick(28);
    check_bit("rx clamp", 1'b1, cause.rx_clamp);
    check_bit("pin short", 1'b1, cause.pin_short);
    check_bit("tx off clamp", 1'b0, tx_en);
    clamp <= 1'b0;
    tick(4);
    check_bit("rx clamp gone", 1'b0, cause.rx_clamp);
    ext_dom <= 1'b0;
    tick(4);
    renormal();
    check_bit("flag cleared 2", 1'b1, err_n);
    // Bus held dominant by another node.
    ext_dom <= 1'b1;
    tick(68);
    check_bit("bus clamp", 1'b1, cause.bus_clamp);
    check_bit("error_n bus", 1'b0, err_n);
    check_bit("tx on bus clamp", 1'b1, tx_en);
    check_bit("rxd low", 1'b0, rxd);
    ext_dom <= 1'b0;
    tick(4);
    check_bit("bus clamp gone", 1'b0, cause.bus_clamp);
    check_bit("rxd high", 1'b1, rxd);
    check_bit("error_n released", 1'b1, err_n);
    renormal();
    // Overtemperature latches the transmitter off.
    overtemp <= 1'b1;
    tick(4);
    overtemp <= 1'b0;
    tick(6);
    check_bit("overtemp", 1'b1, cause.overtemp);
    check_bit("tx off hot", 1'b0, tx_en);
    renormal();
    check_bit("tx on cool", 1'b1, tx_en);
    // Each supply in turn drops out.
    for (int k = 0; k < 3; k++) begin
      uv <= 3'h1 << k;
      tick(4);
      check_bit("engaged uv", 1'b0, engaged);
      check_bit("wake comparator", k != 0, wake_cmp);
      check_bit("local wake", k != 0, lwake);
      uv <= 3'h0;
      tick(4);
      check_bit("engaged again", 1'b1, engaged);
    end
    // Wake patterns in Standby: one valid, the rest too short or too slow.
    bus_op(1'b1, 4'h0, 32'h0, r);
    tick(4);
    for (int p = 0; p < 5; p++) begin
      wakes = 0;
      ext_dom <= 1'b1;
      tick(pat[p][0]);
      ext_dom <= 1'b0;
      tick(pat[p][1]);
      ext_dom <= 1'b1;
      tick(pat[p][2]);
      ext_dom <= 1'b0;
      tick(120);
      check_word("wake count", 32'(pat[p][3]), 32'(wakes));
    end
    // Sticky wake bit: a clear with lane 0 disabled must be ignored.
    bus_op(1'b0, 4'h8, 32'h0, r);
    check_word("wake sticky", 32'h1, r);
    be <= 4'h0;
    bus_op(1'b1, 4'h8, 32'h1, r);
    bus_op(1'b0, 4'h8, 32'h0, r);
    check_word("wake masked clear", 32'h1, r);
    be <= 4'hF;
    bus_op(1'b1, 4'h8, 32'h1, r);
    bus_op(1'b0, 4'h8, 32'h0, r);
    check_word("wake cleared", 32'h0, r);
    finish_test();
  end
endmodule

`default_nettype wire
